// *** common/sbs_pkg.sv ***
// Constants, register map and carrier types of the serial baud select and shift mode block.
// Function
// - Timer one rate source gives bit rate of overflows times two-to-double-rate over 32.
// - Timer one 8-bit auto-reload gives oscillator over 12 times (256 minus reload).
// - Each clock-select bit picks timer two for that direction only; any one of them puts timer two in baud mode.
// - First port selects live in timer two control, second port's in power control.
// - In baud mode each timer two rollover reloads both count bytes from reload pair.
// - With timer two as source, bit rate equals timer two overflow rate over 16.
// - Timer two baud rate equals oscillator over 32 times (65536 minus reload pair).
// - Baud mode applies only while some receive or transmit clock-select bit is one.
// - In baud mode a timer two rollover sets no overflow flag and raises nothing.
// - In baud mode an external pin falling edge sets external flag without reload.
// - As baud generator in timer operation, timer two counts every state time.
// - Shift mode moves eight bits LSB first on receive pin, clock on transmit pin.
// - Buffer write loads marker one, transmission starts one full machine cycle later.
// - Shift clock low in states three to five; transmit register shifts at S6P2.
// - After MSB reaches output, marker just left of it, final shift; send ends, flag sets, tenth cycle S1P1.
// - Reception starts with enable set, flag clear; preload 11111110, receive follows.
// - Receive clock toggles S3P1 and S6P1; shift left taking pin sampled at S5P2.
// - Preloaded zero at top gives final shift, buffer load, flag on tenth cycle.
// - Transmit flag sets after eighth bit time; software must clear it.
package sbs_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFS_SERIAL_CONTROL_REGISTER  = 8'h00;
	localparam logic [7:0] OFS_SERIAL_BUFFER  = 8'h04;
	localparam logic [7:0] OFS_TIMER_TWO_CONTROL_REGISTER = 8'h08;
	localparam logic [7:0] OFS_POWER_CONTROL_REGISTER  = 8'h0C;
	localparam logic [7:0] OFS_TIMER_MODE_REGISTER  = 8'h10;
	localparam logic [7:0] OFS_T1CNT = 8'h14;
	localparam logic [7:0] OFS_T1RUN = 8'h18;
	localparam logic [7:0] OFS_T2CNT = 8'h1C;
	localparam logic [7:0] OFS_RCAP  = 8'h20;
	// Field positions.
	localparam int SC_SM0 = 7;
	localparam int SC_SM1 = 6;
	localparam int SC_REN = 4;
	localparam int SC_TI  = 1;
	localparam int SC_RI  = 0;
	localparam int T2_TF2  = 7;
	localparam int T2_TIMER_TWO_EXTERNAL_FLAG = 6;
	localparam int T2_RCLK = 5;
	localparam int T2_TX_CLOCK_SOURCE_SELECT = 4;
	localparam int T2_EXEN = 3;
	localparam int T2_TR2  = 2;
	localparam int T2_CT2  = 1;
	localparam int PC_DOUBLE_RATE_SELECT  = 7;
	localparam int PC_SECOND_PORT_RX_CLOCK_SELECT = 5;
	localparam int PC_SECOND_PORT_TX_CLOCK_SELECT = 4;
	localparam int TM_T1_HI = 5;
	localparam int TM_T1_LO = 4;
	localparam logic [1:0] T1M_13 = 2'b00;
	localparam logic [1:0] T1M_16 = 2'b01;
	localparam logic [1:0] T1M_8R = 2'b10;
	// Machine cycle phases, one oscillator period each.
	localparam logic [3:0] PH_S1P1 = 4'h0;
	localparam logic [3:0] PH_S3P1 = 4'h4;
	localparam logic [3:0] PH_S5P2 = 4'h9;
	localparam logic [3:0] PH_S6P2 = 4'hB;
	localparam logic [8:0] TX_MARK    = 9'h001;
	localparam logic [7:0] RX_PRELOAD = 8'hFE;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_ARM  = 2'b01,
		TX_SEND = 2'b10,
		TX_LAST = 2'b11
	} sbs_tx_e;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_ARM  = 3'b001,
		RX_WAIT = 3'b010,
		RX_RECV = 3'b011,
		RX_LAST = 3'b100
	} sbs_rx_e;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} sbs_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} sbs_axi_rsp_s;

	typedef struct packed {
		logic rxd_in;
		logic timer_two_external_pin;
		logic t2_count;
	} sbs_pin_in_s;

	typedef struct packed {
		logic rxd_out;
		logic rxd_oe;
		logic txd_out;
		logic txd_oe;
	} sbs_pin_out_s;

	typedef struct packed {
		logic p1_tx;
		logic p1_rx;
		logic p2_tx;
		logic p2_rx;
	} sbs_tick_s;

	typedef struct packed {
		logic [3:0]   ph;
		logic [7:0]   serial_control_register;
		logic [7:0]   timer_mode_register;
		logic [7:0]   th1;
		logic [7:0]   tl1;
		logic [7:0]   timer_two_control_register;
		logic [7:0]   power_control_register;
		logic [7:0]   rbuf;
		logic [7:0]   txdat;
		logic [7:0]   rsr;
		logic [8:0]   tsr;
		logic [15:0]  t2cnt;
		logic [15:0]  rcap;
		logic         t1_run;
		logic         t1_half;
		logic         timer_two_external_pin_prev;
		logic         t2c_prev;
		logic         tx_pend;
		logic         rsamp;
		sbs_tx_e      tx;
		sbs_rx_e      rx;
		logic         bvalid;
		logic [1:0]   bresp;
		logic         rvalid;
		logic [1:0]   rresp;
		logic [31:0]  rdata;
		sbs_pin_out_s pins;
		sbs_tick_s    tick;
	} sbs_state_s;

	localparam sbs_state_s ST_RESET = '0;
endpackage

// *** logic/sbs_serial_baud_shift.sv ***
// Baud rate sources for both serial ports and the synchronous shift mode engine.
`timescale 1ns/1ns
module sbs_serial_baud_shift (
	// Clock and reset.
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// Register bus.
	input  wire sbs_pkg::sbs_axi_req_s axi_req,
	output sbs_pkg::sbs_axi_rsp_s      axi_rsp,
	// Serial pins.
	input  wire sbs_pkg::sbs_pin_in_s  pin_in,
	output sbs_pkg::sbs_pin_out_s      pin_out,
	// Sixteen-times bit rate ticks for the framers of both ports.
	output sbs_pkg::sbs_tick_s         rate_tick
);
	import sbs_pkg::*;

	sbs_state_s s_reg;
	sbs_state_s s_next;
	logic       aw_take;
	logic       ar_take;
	logic       baud;

	function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] d,
			input logic [3:0] st);
		logic [15:0] r;
		r = o;
		if (st[0]) r[7:0] = d[7:0];
		if (st[1]) r[15:8] = d[15:8];
		return r;
	endfunction

	assign aw_take = axi_req.awvalid & axi_req.wvalid & ~s_reg.bvalid;
	assign ar_take = axi_req.arvalid & ~s_reg.rvalid;
	// Any select bit of either port puts timer two into baud mode.
	assign baud = s_reg.timer_two_control_register[T2_RCLK] | s_reg.timer_two_control_register[T2_TX_CLOCK_SOURCE_SELECT]
		| s_reg.power_control_register[PC_SECOND_PORT_RX_CLOCK_SELECT] | s_reg.power_control_register[PC_SECOND_PORT_TX_CLOCK_SELECT];

	assign axi_rsp = '{awready: aw_take, wready: aw_take, bvalid: s_reg.bvalid,
		bresp: s_reg.bresp, arready: ~s_reg.rvalid, rvalid: s_reg.rvalid,
		rdata: s_reg.rdata, rresp: s_reg.rresp};
	assign pin_out   = s_reg.pins;
	assign rate_tick = s_reg.tick;

	always_comb begin
		logic [15:0] c16;
		logic [12:0] c13;
		logic [7:0]  v;
		logic        mend;
		logic        m0;
		logic        t1_ovf;
		logic        t1_tick;
		logic        t2_inc;
		logic        t2_ovf;
		logic        rx_ok;
		logic        snd;
		logic        rcv;
		s_next  = s_reg;
		c16     = '0;
		c13     = '0;
		v       = '0;
		t1_ovf  = 1'b0;
		t2_ovf  = 1'b0;
		t1_tick = 1'b0;
		t2_inc  = 1'b0;
		m0      = 1'b0;
		rx_ok   = 1'b0;
		snd     = 1'b0;
		rcv     = 1'b0;
		mend    = s_reg.ph == PH_S6P2;
		s_next.ph = mend ? PH_S1P1 : s_reg.ph + 4'h1;

		// Register writes; hardware flag sets below come later and so win.
		if (aw_take) begin
			s_next.bvalid = 1'b1;
			s_next.bresp  = RESP_OKAY;
			case (axi_req.awaddr)
				OFS_SERIAL_CONTROL_REGISTER: begin
					if (axi_req.wstrb[0]) s_next.serial_control_register = axi_req.wdata[7:0];
				end
				OFS_SERIAL_BUFFER: begin
					if (axi_req.wstrb[0]) begin
						s_next.txdat = axi_req.wdata[7:0];
						s_next.tx_pend = s_reg.serial_control_register[SC_SM0:SC_SM1] == 2'b00;
					end
				end
				OFS_TIMER_TWO_CONTROL_REGISTER: begin
					// Which register holds which port's selects.
					if (axi_req.wstrb[0]) s_next.timer_two_control_register = axi_req.wdata[7:0];
				end
				OFS_POWER_CONTROL_REGISTER: begin
					if (axi_req.wstrb[0]) s_next.power_control_register = axi_req.wdata[7:0];
				end
				OFS_TIMER_MODE_REGISTER: begin
					if (axi_req.wstrb[0]) s_next.timer_mode_register = axi_req.wdata[7:0];
				end
				OFS_T1CNT: begin
					{s_next.th1, s_next.tl1} = merge16({s_reg.th1, s_reg.tl1},
						axi_req.wdata, axi_req.wstrb);
				end
				OFS_T1RUN: begin
					if (axi_req.wstrb[0]) s_next.t1_run = axi_req.wdata[0];
				end
				OFS_T2CNT: begin
					s_next.t2cnt = merge16(s_reg.t2cnt, axi_req.wdata, axi_req.wstrb);
				end
				OFS_RCAP: begin
					s_next.rcap = merge16(s_reg.rcap, axi_req.wdata, axi_req.wstrb);
				end
				default: s_next.bresp = RESP_SLVERR;
			endcase
		end else if (s_reg.bvalid && axi_req.bready) begin
			s_next.bvalid = 1'b0;
		end

		if (ar_take) begin
			s_next.rvalid = 1'b1;
			s_next.rresp  = RESP_OKAY;
			case (axi_req.araddr)
				OFS_SERIAL_CONTROL_REGISTER:  s_next.rdata = {24'h000000, s_reg.serial_control_register};
				OFS_SERIAL_BUFFER:  s_next.rdata = {24'h000000, s_reg.rbuf};
				OFS_TIMER_TWO_CONTROL_REGISTER: s_next.rdata = {24'h000000, s_reg.timer_two_control_register};
				OFS_POWER_CONTROL_REGISTER:  s_next.rdata = {24'h000000, s_reg.power_control_register};
				OFS_TIMER_MODE_REGISTER:  s_next.rdata = {24'h000000, s_reg.timer_mode_register};
				OFS_T1CNT: s_next.rdata = {16'h0000, s_reg.th1, s_reg.tl1};
				OFS_T1RUN: s_next.rdata = {31'h00000000, s_reg.t1_run};
				OFS_T2CNT: s_next.rdata = {16'h0000, s_reg.t2cnt};
				OFS_RCAP:  s_next.rdata = {16'h0000, s_reg.rcap};
				default: begin
					s_next.rdata = 32'h00000000;
					s_next.rresp = RESP_SLVERR;
				end
			endcase
		end else if (s_reg.rvalid && axi_req.rready) begin
			s_next.rvalid = 1'b0;
		end

		// Timer one counts once per machine cycle.
		if (s_reg.t1_run && mend) begin
			case (s_reg.timer_mode_register[TM_T1_HI:TM_T1_LO])
				T1M_13: begin
					c13 = {s_reg.th1, s_reg.tl1[4:0]} + 13'h0001;
					t1_ovf = &{s_reg.th1, s_reg.tl1[4:0]};
					{s_next.th1, s_next.tl1[4:0]} = c13;
				end
				T1M_16: begin
					c16 = {s_reg.th1, s_reg.tl1} + 16'h0001;
					t1_ovf = &{s_reg.th1, s_reg.tl1};
					{s_next.th1, s_next.tl1} = c16;
				end
				T1M_8R: begin
					// Rate is oscillator over 12 times (256 minus reload).
					t1_ovf = &s_reg.tl1;
					s_next.tl1 = t1_ovf ? s_reg.th1 : s_reg.tl1 + 8'h01;
				end
				default: t1_ovf = 1'b0;
			endcase
		end
		// Halving without double rate gives 2^double_rate_select/32 of the overflow rate per bit.
		if (t1_ovf) s_next.t1_half = ~s_reg.t1_half;
		t1_tick = t1_ovf & (s_reg.power_control_register[PC_DOUBLE_RATE_SELECT] | s_reg.t1_half);

		// Timer two: every state time in baud mode, else per machine cycle; with the count select bit set it counts t2_count falling edges instead.
		s_next.timer_two_external_pin_prev = pin_in.timer_two_external_pin;
		s_next.t2c_prev  = pin_in.t2_count;
		if (s_reg.timer_two_control_register[T2_CT2])
			t2_inc = s_reg.t2c_prev & ~pin_in.t2_count;
		else
			t2_inc = baud ? s_reg.ph[0] : mend;
		t2_inc = t2_inc & s_reg.timer_two_control_register[T2_TR2];
		if (t2_inc) begin
			t2_ovf = &s_reg.t2cnt;
			// Rollover reloads both bytes from the reload pair.
			s_next.t2cnt = t2_ovf ? s_reg.rcap : s_reg.t2cnt + 16'h0001;
			// Overflow flag only outside baud mode.
			if (t2_ovf && !baud) s_next.timer_two_control_register[T2_TF2] = 1'b1;
		end
		if (s_reg.timer_two_control_register[T2_EXEN] && s_reg.timer_two_external_pin_prev && !pin_in.timer_two_external_pin) begin
			s_next.timer_two_control_register[T2_TIMER_TWO_EXTERNAL_FLAG] = 1'b1;
			// In baud mode the edge is only an extra interrupt source.
			if (!baud) s_next.t2cnt = s_reg.rcap;
		end

		// Per-direction source choice; timer two overflows are already 16 per bit.
		s_next.tick.p1_tx = s_reg.timer_two_control_register[T2_TX_CLOCK_SOURCE_SELECT] ? t2_ovf : t1_tick;
		s_next.tick.p1_rx = s_reg.timer_two_control_register[T2_RCLK] ? t2_ovf : t1_tick;
		s_next.tick.p2_tx = s_reg.power_control_register[PC_SECOND_PORT_TX_CLOCK_SELECT] ? t2_ovf : t1_tick;
		s_next.tick.p2_rx = s_reg.power_control_register[PC_SECOND_PORT_RX_CLOCK_SELECT] ? t2_ovf : t1_tick;

		// Shift mode transmit.
		m0 = s_next.serial_control_register[SC_SM0:SC_SM1] == 2'b00;
		case (s_reg.tx)
			TX_IDLE: begin
				if (s_reg.tx_pend && mend) begin
					s_next.tsr = {1'b1, s_reg.txdat};
					s_next.tx_pend = 1'b0;
					s_next.tx = TX_ARM;
				end
			end
			TX_ARM: begin
				if (mend) s_next.tx = TX_SEND;
			end
			TX_SEND: begin
				if (mend) begin
					// Shift right with zeros from the left.
					if (s_reg.tsr[8:1] == TX_MARK[7:0]) s_next.tx = TX_LAST;
					s_next.tsr = {1'b0, s_reg.tsr[8:1]};
				end
			end
			TX_LAST: begin
				if (s_reg.ph == PH_S1P1) begin
					s_next.tx = TX_IDLE;
					s_next.serial_control_register[SC_TI] = 1'b1;
				end
			end
			default: s_next.tx = TX_IDLE;
		endcase

		// Shift mode receive.
		rx_ok = m0 & s_next.serial_control_register[SC_REN] & ~s_next.serial_control_register[SC_RI];
		case (s_reg.rx)
			RX_IDLE: begin
				if (rx_ok && mend) s_next.rx = RX_ARM;
			end
			RX_ARM: begin
				if (mend) begin
					s_next.rx = rx_ok ? RX_WAIT : RX_IDLE;
					if (rx_ok) s_next.rsr = RX_PRELOAD;
				end
			end
			RX_WAIT: s_next.rx = RX_RECV;
			RX_RECV: begin
				if (s_reg.ph == PH_S5P2) s_next.rsamp = pin_in.rxd_in;
				if (mend) begin
					v = {s_reg.rsr[6:0], s_reg.rsamp};
					s_next.rsr = v;
					if (!s_reg.rsr[7]) begin
						// First bit in ends at the top, so reverse for LSB first.
						s_next.rbuf = {<<{v}};
						s_next.rx = RX_LAST;
					end
				end
			end
			RX_LAST: begin
				if (s_reg.ph == PH_S1P1) begin
					s_next.rx = RX_IDLE;
					s_next.serial_control_register[SC_RI] = 1'b1;
				end
			end
			default: s_next.rx = RX_IDLE;
		endcase

		// Pins are registered against the next phase so they line up with it.
		snd = (s_next.tx == TX_SEND) | (s_next.tx == TX_LAST);
		rcv = (s_next.rx == RX_RECV) | (s_next.rx == RX_LAST);
		s_next.pins.txd_out = (snd | rcv)
			? ~(s_next.ph inside {[PH_S3P1:PH_S5P2]}) : 1'b1;
		s_next.pins.txd_oe  = m0;
		s_next.pins.rxd_out = s_next.tsr[0];
		s_next.pins.rxd_oe  = snd;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_reg <= ST_RESET;
		else
			s_reg <= s_next;
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_tx_flag_tenth: assert property (
		(s_reg.tx == TX_IDLE && s_reg.tx_pend && s_reg.ph == PH_S6P2)
		|-> ##109 (s_reg.tx == TX_LAST && s_reg.ph == PH_S1P1) ##1 s_reg.serial_control_register[SC_TI])
		else $error("transmit flag not set in the tenth machine cycle");
	a_rx_flag_tenth: assert property (
		(s_reg.rx == RX_ARM && s_reg.ph == PH_S6P2 && s_next.rx == RX_WAIT)
		|-> ##97 (s_reg.rx == RX_LAST && s_reg.ph == PH_S1P1) ##1 s_reg.serial_control_register[SC_RI])
		else $error("receive flag not set in the tenth machine cycle");
	a_rx_preload_seq: assert property (
		(s_reg.rx == RX_ARM && s_next.rx == RX_WAIT)
		|=> (s_reg.rsr == RX_PRELOAD) ##1 (s_reg.rx == RX_RECV))
		else $error("receive preload or start wrong");
	a_shift_clock_shape: assert property (
		(s_reg.tx == TX_SEND) |-> (s_reg.pins.txd_out == !(s_reg.ph inside {[4:9]})))
		else $error("shift clock level wrong during send");
	a_tx_shift_moment: assert property (
		(s_reg.tx == TX_SEND && s_reg.ph != PH_S6P2) |=> $stable(s_reg.tsr))
		else $error("transmit register moved outside S6P2");
	a_baud_no_flag: assert property (
		(baud && !aw_take && !s_reg.timer_two_control_register[T2_TF2]) |=> !s_reg.timer_two_control_register[T2_TF2])
		else $error("overflow flag set in baud mode");
	a_baud_reload: assert property (
		(baud && !aw_take && s_reg.timer_two_control_register[T2_TR2] && !s_reg.timer_two_control_register[T2_CT2] && s_reg.ph[0]
		&& s_reg.t2cnt == 16'hFFFF) |=> (s_reg.t2cnt == $past(s_reg.rcap)))
		else $error("no reload on rollover");
	a_baud_state_rate: assert property (
		(baud && !aw_take && s_reg.timer_two_control_register[T2_TR2] && !s_reg.timer_two_control_register[T2_CT2]
		&& s_reg.t2cnt != 16'hFFFF)
		|=> (s_reg.t2cnt == $past(s_reg.t2cnt) + 16'($past(s_reg.ph[0]))))
		else $error("timer two not counting every state time");
	a_ext_edge_flag: assert property (
		(baud && s_reg.timer_two_control_register[T2_EXEN] && s_reg.timer_two_external_pin_prev && !pin_in.timer_two_external_pin)
		|=> s_reg.timer_two_control_register[T2_TIMER_TWO_EXTERNAL_FLAG])
		else $error("external flag not set");
	a_rxd_released: assert property (
		(s_reg.rx == RX_RECV) |-> !s_reg.pins.rxd_oe)
		else $error("receive pin driven while receiving");

	// Shift mode sequencing and pin shapes.
	a_send_one_cycle: assert property (
		(s_reg.tx == TX_ARM && s_reg.ph == PH_S1P1)
		|-> ##11 (s_reg.tx == TX_ARM && s_reg.ph == PH_S6P2) ##1 (s_reg.tx == TX_SEND))
		else $error("send not started one machine cycle after load");

	a_rx_clock_shape: assert property (
		(s_reg.rx == RX_RECV)
		|-> (s_reg.pins.txd_out == !(s_reg.ph inside {[PH_S3P1:PH_S5P2]})))
		else $error("shift clock level wrong during receive");

	a_rx_sample_point: assert property (
		(s_reg.rx == RX_RECV && s_reg.ph == PH_S5P2)
		|=> (s_reg.rsamp == $past(pin_in.rxd_in)))
		else $error("receive pin not sampled at S5P2");

	a_rxd_data_bit: assert property (
		(s_reg.tx == TX_SEND) |-> (s_reg.pins.rxd_out == s_reg.tsr[0]))
		else $error("receive pin does not show the transmit bit");

	// An idle clock line must sit high, or the far side sees a false edge.
	a_txd_idle_high: assert property (
		(s_reg.pins.txd_oe && s_reg.tx == TX_IDLE
		&& s_reg.rx inside {RX_IDLE, RX_ARM, RX_WAIT}) |-> s_reg.pins.txd_out)
		else $error("shift clock not high while idle");

	// Timer one and flag behaviour.
	a_t1_auto_reload: assert property (
		(s_reg.t1_run && s_reg.ph == PH_S6P2 && !aw_take
		&& s_reg.timer_mode_register[TM_T1_HI:TM_T1_LO] == T1M_8R && &s_reg.tl1)
		|=> (s_reg.tl1 == $past(s_reg.th1)))
		else $error("timer one low byte not reloaded");

	a_ti_held_set: assert property (
		(s_reg.serial_control_register[SC_TI] && !aw_take) |=> s_reg.serial_control_register[SC_TI])
		else $error("transmit flag cleared without software");

	c_tx_done: cover property (s_reg.tx == TX_LAST ##1 s_reg.tx == TX_IDLE);
	c_rx_done: cover property (s_reg.rx == RX_LAST ##1 s_reg.rx == RX_IDLE);
	c_baud_roll: cover property (baud && s_reg.tick.p1_tx);
	c_ext_flag: cover property (baud && s_reg.timer_two_control_register[T2_TIMER_TWO_EXTERNAL_FLAG]);
	c_t1_tick: cover property (!baud && s_reg.tick.p1_rx);
endmodule

// *** bench/sbs_shift_partner.sv ***
// Behavioural external shift register on the far side of the shift mode link.
`timescale 1ns/1ns
module sbs_shift_partner (
	// Clock and preload from the bench.
	input  wire logic       aclk,
	input  wire logic       load,
	input  wire logic [7:0] load_byte,
	// Link lines.
	input  wire logic       shift_clk,
	input  wire logic       data_in,
	input  wire logic       data_oe,
	output logic            data_out,
	output logic [7:0]      captured
);
	logic [7:0] out_sr;
	logic       clk_prev;

	assign data_out = out_sr[0];

	always_ff @(posedge aclk) begin
		clk_prev <= shift_clk;
		if (load) begin
			out_sr   <= load_byte;
			captured <= 8'h00;
		end else if (shift_clk && !clk_prev) begin
			if (data_oe) begin
				captured <= {data_in, captured[7:1]};
			end else begin
				// Spent bits are replaced by a changing pattern, so stale data never looks valid.
				out_sr <= {~out_sr[0], out_sr[7:1]};
			end
		end
	end
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the baud select and shift mode block.
`timescale 1ns/1ns
module testbench;
	import sbs_pkg::*;
	logic         aclk;
	logic         aresetn;
	sbs_axi_req_s req;
	sbs_axi_rsp_s rsp;
	sbs_pin_in_s  pin_i;
	sbs_pin_out_s pin_o;
	sbs_tick_s    tick;
	logic         p_load;
	logic [7:0]   p_byte;
	logic         p_out;
	logic [7:0]   p_cap;
	logic         timer_two_external_pin_drv;
	logic         sclk;
	logic         sclk_prev;
	logic         clr;
	logic [31:0]  rd;
	logic [1:0]   rs;
	logic [7:0]   bytes [2];
	int           tk_cnt [4];
	int           fall_cnt;
	int           oe_cnt;
	int           low_cnt;
	int           cycles;
	int           bad_count;
	int           n_compared;

	// The shift clock line idles high when nobody drives it.
	assign sclk = pin_o.txd_oe ? pin_o.txd_out : 1'b1;
	assign pin_i = {pin_o.rxd_oe ? pin_o.rxd_out : p_out, timer_two_external_pin_drv, 1'b1};

	sbs_serial_baud_shift uut (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.axi_req   (req),
		.axi_rsp   (rsp),
		.pin_in    (pin_i),
		.pin_out   (pin_o),
		.rate_tick (tick)
	);

	sbs_shift_partner partner (
		.aclk      (aclk),
		.load      (p_load),
		.load_byte (p_byte),
		.shift_clk (sclk),
		.data_in   (pin_o.rxd_out),
		.data_oe   (pin_o.rxd_oe),
		.data_out  (p_out),
		.captured  (p_cap)
	);

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		sclk_prev <= sclk;
		for (int i = 0; i < 4; i++) begin
			tk_cnt[i] <= clr ? 0 : tk_cnt[i] + tick[i];
		end
		fall_cnt <= clr ? 0 : fall_cnt + (sclk_prev && !sclk);
		oe_cnt <= clr ? 0 : oe_cnt + pin_o.rxd_oe;
		low_cnt <= clr ? 0 : low_cnt + (pin_o.rxd_oe && !sclk);
		if (cycles == 20000) begin
			$display("timeout after %0d cycles", cycles);
			bad_count++;
			conclude();
		end
	end

	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	// Counts over a window whose start is not aligned to the rate may be off by one.
	task automatic check_near(input string name, input int exp, input int got);
		n_compared++;
		if (got < exp - 1 || got > exp + 1) begin
			bad_count++;
			$display("wrong value %s: expected %0d, seen %0d", name, exp, got);
		end
	endtask

	// Values read right after an edge are the ones that edge sampled.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready === 1'b1 && rsp.wready === 1'b1) begin
				req.awvalid <= 1'b0;
				req.wvalid <= 1'b0;
			end
			if (rsp.bvalid === 1'b1) begin
				rs = rsp.bresp;
				done = 1'b1;
			end
		end
	endtask

	task automatic axi_read(input logic [7:0] a);
		logic done;
		done = 1'b0;
		req.araddr <= a;
		req.arvalid <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready === 1'b1) begin
				req.arvalid <= 1'b0;
			end
			if (rsp.rvalid === 1'b1) begin
				rd = rsp.rdata;
				rs = rsp.rresp;
				done = 1'b1;
			end
		end
	endtask

	task automatic wait_flag(input int bitpos);
		rd = '0;
		while (rd[bitpos] !== 1'b1) begin
			axi_read(OFS_SERIAL_CONTROL_REGISTER);
		end
	endtask

	task automatic restart(input logic [7:0] b);
		p_byte <= b;
		p_load <= 1'b1;
		clr <= 1'b1;
		@(posedge aclk);
		p_load <= 1'b0;
		clr <= 1'b0;
	endtask

	initial begin
		aresetn = 1'b0;
		req = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		p_load = 1'b0;
		p_byte = 8'h00;
		timer_two_external_pin_drv = 1'b1;
		clr = 1'b1;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_read(OFS_SERIAL_CONTROL_REGISTER);
		check("serial_control_register reset", 32'h0000_0000, rd);
		axi_read(OFS_TIMER_TWO_CONTROL_REGISTER);
		check("timer_two_control_register reset", 32'h0000_0000, rd);
		axi_read(8'h24);
		check("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		check("unmapped read data", 32'h0000_0000, rd);
		axi_write(8'h24, 32'h0000_00FF);
		check("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		for (int i = 0; i < 2; i++) begin
			axi_write(OFS_TIMER_TWO_CONTROL_REGISTER, 32'h0000_0000);
			axi_write(OFS_RCAP, 32'(65534 - 2 * i));
			axi_read(OFS_RCAP);
			check("reload pair", 32'(65534 - 2 * i), rd);
			axi_write(OFS_T2CNT, 32'(65534 - 2 * i));
			axi_write(OFS_POWER_CONTROL_REGISTER, 32'h0000_0001 << PC_SECOND_PORT_TX_CLOCK_SELECT);
			axi_write(OFS_TIMER_TWO_CONTROL_REGISTER, 32'h0000_001C);
			restart(8'h00);
			repeat (400) @(posedge aclk);
			check_near("p1 tx ticks", 400 / (4 + 4 * i), tk_cnt[3]);
			check_near("p2 tx ticks", 400 / (4 + 4 * i), tk_cnt[1]);
			check_near("p1 rx ticks", 0, tk_cnt[2]);
		end
		timer_two_external_pin_drv <= 1'b0;
		repeat (3) @(posedge aclk);
		axi_read(OFS_TIMER_TWO_CONTROL_REGISTER);
		check("t2 flags", 32'h0000_0040, rd & 32'h0000_00C0);
		axi_write(OFS_TIMER_TWO_CONTROL_REGISTER, 32'h0000_0000);
		axi_write(OFS_TIMER_MODE_REGISTER, 32'({T1M_8R, 4'h0}));
		axi_write(OFS_T1CNT, 32'h0000_FFFF);
		axi_write(OFS_T1RUN, 32'h0000_0001);
		for (int j = 0; j < 2; j++) begin
			axi_write(OFS_POWER_CONTROL_REGISTER, 32'(j) << PC_DOUBLE_RATE_SELECT);
			restart(8'h00);
			repeat (1200) @(posedge aclk);
			check_near("timer one ticks", 50 * (j + 1), tk_cnt[2]);
		end
		axi_write(OFS_T1RUN, 32'h0000_0000);
		axi_write(OFS_POWER_CONTROL_REGISTER, 32'h0000_0000);
		bytes = '{8'hA5, 8'h80};
		foreach (bytes[k]) begin
			restart(8'h00);
			axi_write(OFS_SERIAL_BUFFER, 32'(bytes[k]));
			wait_flag(SC_TI);
			check("sent byte", 32'(bytes[k]), 32'(p_cap));
			check_near("send cycles", 97, oe_cnt);
			check("send clocks", 32'h0000_0008, 32'(fall_cnt));
			check_near("clock low cycles", 48, low_cnt);
			axi_write(OFS_SERIAL_CONTROL_REGISTER, 32'h0000_0000);
		end
		bytes = '{8'h3C, 8'hC3};
		foreach (bytes[k]) begin
			restart(bytes[k]);
			axi_write(OFS_SERIAL_CONTROL_REGISTER, 32'h0000_0001 << SC_REN);
			wait_flag(SC_RI);
			axi_read(OFS_SERIAL_BUFFER);
			check("received byte", 32'(bytes[k]), rd);
			check("receive clocks", 32'h0000_0008, 32'(fall_cnt));
			restart(bytes[k]);
			repeat (300) @(posedge aclk);
			check("held receive clocks", 32'h0000_0000, 32'(fall_cnt));
		end
		conclude();
	end
endmodule
